// [common/rtc_i2c_pkg.sv]
`default_nettype none
package rtc_i2c_pkg;

  // byte framing
  localparam int          BYTE_W       = 8;
  localparam logic [6:0]  SLAVE_ADDR   = 7'h68;  // 1101000
  localparam logic [3:0]  ACK_BIT_IDX  = 4'h8;   // ninth clock of every byte
  localparam logic [2:0]  LAST_TX_BIT  = 3'h7;
  localparam logic [7:0]  PTR_RESET    = 8'h00;

  // timing: master serial clock derived from the system clock
  localparam int SYS_CLK_HZ    = 25_000_000;
  localparam int SCL_FREQ_HZ   = 400_000;        // fast-mode ceiling
  // quarter of a bit period, rounded up so the bus rate never exceeds the limit
  localparam int SCL_QUARTER_CYCLES = (SYS_CLK_HZ + 4 * SCL_FREQ_HZ - 1) / (4 * SCL_FREQ_HZ);

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RECV = 5'h02,
    S_ACK  = 5'h04,
    S_SEND = 5'h08,
    S_SACK = 5'h10
  } slave_state_t;

  typedef enum logic [2:0] {
    K_ADDR = 3'h1,
    K_PTR  = 3'h2,
    K_DATA = 3'h4
  } byte_kind_t;

  typedef enum logic [3:0] {
    M_IDLE  = 4'h1,
    M_START = 4'h2,
    M_BIT   = 4'h4,
    M_STOP  = 4'h8
  } master_state_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } master_op_t;

endpackage : rtc_i2c_pkg
`default_nettype wire

// [common/rtc_i2c_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rtc_i2c_if;
  logic masterSclO;
  logic masterSclOe;
  logic masterSdaO;
  logic masterSdaOe;
  logic slaveSdaO;
  logic slaveSdaOe;
  logic scl;
  logic sda;

  // open-drain wired-and with pull-ups: any enabled low output pulls the line
  assign scl = ~(masterSclOe & ~masterSclO);
  assign sda = ~((masterSdaOe & ~masterSdaO) | (slaveSdaOe & ~slaveSdaO));

  modport master (output masterSclO, output masterSclOe, output masterSdaO, output masterSdaOe,
                  input scl, input sda);
  modport slave  (output slaveSdaO, output slaveSdaOe, input scl, input sda);
endinterface : rtc_i2c_if
`default_nettype wire

// [src/i2c_line_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_line_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sclS,
  output logic      sdaS,
  output logic      sclRise,
  output logic      sclFall,
  output logic      startDet,
  output logic      stopDet
);
  // bit 0 carries the clock line, bit 1 the data line
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;

  // two flops before any logic; reset to the idle-high bus level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      meta_q <= {sdaIn, sclIn};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // conditions seen only while the clock line stays high on both samples
  assign sclS     = sync_q[0];
  assign sdaS     = sync_q[1];
  assign sclRise  = sync_q[0] & ~prev_q[0];
  assign sclFall  = ~sync_q[0] & prev_q[0];
  assign startDet = sync_q[0] & prev_q[0] & prev_q[1] & ~sync_q[1];
  assign stopDet  = sync_q[0] & prev_q[0] & ~prev_q[1] & sync_q[1];
endmodule : i2c_line_sync
`default_nettype wire

// [src/rtc_i2c_slave_port.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - falling data while clock high starts transfer
// - rising data while clock high ends transfer
// - data changes only while clock low
// - one clock pulse per bit
// - master brackets transfers, no byte limit
// - eight bits MSB first, then acknowledge
// - master gives extra acknowledge clock pulse
// - acknowledger holds data low through high
// - on master nack release line, stop sending
// - repeated start restarts address reception
// - acknowledge only matching fixed address
// - direction bit zero writes, one reads
// - first write byte loads register pointer
// - store data bytes, acknowledge, increment pointer
// - master stops after last acknowledged byte
// - read starts at current pointer value
// - master acks all but last read byte
// - works up to fast-mode clock rate
// - power fail blocks all register access
module rtc_i2c_slave_port #(
  parameter logic [6:0] SlaveAddr = rtc_i2c_pkg::SLAVE_ADDR
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  rtc_i2c_if.slave        link,
  input  wire logic       powerFail,
  input  wire logic [7:0] rdData,
  output logic      [7:0] regPtr,
  output logic      [7:0] accAddr,
  output logic      [7:0] wrData,
  output logic            wrStrobe,
  output logic            rdStrobe
);
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  rtc_i2c_pkg::slave_state_t state_q;
  rtc_i2c_pkg::slave_state_t state_d;
  rtc_i2c_pkg::byte_kind_t   kind_q;
  rtc_i2c_pkg::byte_kind_t   kind_d;
  logic [7:0]                shift_q;
  logic [7:0]                shift_d;
  logic [3:0]                bitCnt_q;
  logic [3:0]                bitCnt_d;
  logic [7:0]                ptr_q;
  logic [7:0]                ptr_d;
  logic [7:0]                accAddr_q;
  logic [7:0]                accAddr_d;
  logic [7:0]                wrData_q;
  logic [7:0]                wrData_d;
  logic                      isRead_q;
  logic                      isRead_d;
  logic                      nack_q;
  logic                      nack_d;
  logic                      sdaOe_q;
  logic                      sdaOe_d;
  logic                      sdaO_q;
  logic                      wrStrobe_q;
  logic                      wrStrobe_d;
  logic                      rdStrobe_q;
  logic                      rdStrobe_d;

  // the slave only listens to the clock line; no clock stretching
  i2c_line_sync u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .sclIn    (link.scl),
    .sdaIn    (link.sda),
    .sclS     (),
    .sdaS     (sdaS),
    .sclRise  (sclRise),
    .sclFall  (sclFall),
    .startDet (startDet),
    .stopDet  (stopDet)
  );

  // byte-level decodes
  logic addrHit;
  logic byteDone;
  logic lastTxFall;
  logic sendLoad;
  assign addrHit    = (shift_q[7:1] == SlaveAddr) && !powerFail;
  assign byteDone   = sclFall && (bitCnt_q == rtc_i2c_pkg::ACK_BIT_IDX);
  assign lastTxFall = sclFall && (bitCnt_q[2:0] == rtc_i2c_pkg::LAST_TX_BIT);
  // fetch the next read byte at the falling edge that closes an acknowledge
  assign sendLoad   = sclFall && !powerFail
                    && (((state_q == rtc_i2c_pkg::S_ACK) && isRead_q)
                     || ((state_q == rtc_i2c_pkg::S_SACK) && !nack_q));

  // protocol engine; start and stop outrank every state so a lost master recovers
  always_comb begin
    state_d    = state_q;
    kind_d     = kind_q;
    shift_d    = shift_q;
    bitCnt_d   = bitCnt_q;
    ptr_d      = ptr_q;
    accAddr_d  = accAddr_q;
    wrData_d   = wrData_q;
    isRead_d   = isRead_q;
    nack_d     = nack_q;
    sdaOe_d    = sdaOe_q;
    wrStrobe_d = 1'b0;
    rdStrobe_d = 1'b0;
    if (startDet) begin
      state_d  = rtc_i2c_pkg::S_RECV;
      kind_d   = rtc_i2c_pkg::K_ADDR;
      bitCnt_d = 4'h0;
      sdaOe_d  = 1'b0;
    end else if (stopDet) begin
      state_d  = rtc_i2c_pkg::S_IDLE;
      sdaOe_d  = 1'b0;
    end else if (sendLoad) begin
      state_d    = rtc_i2c_pkg::S_SEND;
      shift_d    = rdData;
      accAddr_d  = ptr_q;
      rdStrobe_d = 1'b1;
      bitCnt_d   = 4'h0;
      sdaOe_d    = ~rdData[7];
    end else begin
      unique case (state_q)
        rtc_i2c_pkg::S_IDLE: begin
          sdaOe_d = 1'b0;
        end
        rtc_i2c_pkg::S_RECV: begin
          if (sclRise) begin
            shift_d  = {shift_q[6:0], sdaS};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (byteDone) begin
            state_d = rtc_i2c_pkg::S_ACK;
            sdaOe_d = 1'b1;
            unique case (kind_q)
              rtc_i2c_pkg::K_ADDR: begin
                isRead_d = shift_q[0];
                kind_d   = rtc_i2c_pkg::K_PTR;
                if (!addrHit) begin
                  state_d = rtc_i2c_pkg::S_IDLE;
                  sdaOe_d = 1'b0;
                end
              end
              rtc_i2c_pkg::K_PTR: begin
                ptr_d  = shift_q;
                kind_d = rtc_i2c_pkg::K_DATA;
              end
              rtc_i2c_pkg::K_DATA: begin
                wrStrobe_d = 1'b1;
                accAddr_d  = ptr_q;
                wrData_d   = shift_q;
                ptr_d      = ptr_q + 8'h01;
              end
            endcase
            if (powerFail) begin
              state_d    = rtc_i2c_pkg::S_IDLE;
              sdaOe_d    = 1'b0;
              wrStrobe_d = 1'b0;
              ptr_d      = ptr_q;
            end
          end
        end
        rtc_i2c_pkg::S_ACK: begin
          // write side; read side is taken by sendLoad above
          if (sclFall) begin
            sdaOe_d  = 1'b0;
            bitCnt_d = 4'h0;
            state_d  = isRead_q ? rtc_i2c_pkg::S_IDLE : rtc_i2c_pkg::S_RECV;
          end
        end
        rtc_i2c_pkg::S_SEND: begin
          if (lastTxFall) begin
            sdaOe_d = 1'b0;  // release for the master's acknowledge
            ptr_d   = ptr_q + 8'h01;
            state_d = rtc_i2c_pkg::S_SACK;
          end else if (sclFall) begin
            shift_d  = {shift_q[6:0], 1'b0};
            bitCnt_d = bitCnt_q + 4'h1;
            sdaOe_d  = ~shift_q[6];
          end
        end
        rtc_i2c_pkg::S_SACK: begin
          if (sclRise) begin
            nack_d = sdaS;
          end else if (sclFall) begin
            state_d = rtc_i2c_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q    <= rtc_i2c_pkg::S_IDLE;
      kind_q     <= rtc_i2c_pkg::K_ADDR;
      shift_q    <= 8'h00;
      bitCnt_q   <= 4'h0;
      ptr_q      <= rtc_i2c_pkg::PTR_RESET;
      accAddr_q  <= 8'h00;
      wrData_q   <= 8'h00;
      isRead_q   <= 1'b0;
      nack_q     <= 1'b0;
      sdaOe_q    <= 1'b0;
      sdaO_q     <= 1'b0;
      wrStrobe_q <= 1'b0;
      rdStrobe_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      kind_q     <= kind_d;
      shift_q    <= shift_d;
      bitCnt_q   <= bitCnt_d;
      ptr_q      <= ptr_d;
      accAddr_q  <= accAddr_d;
      wrData_q   <= wrData_d;
      isRead_q   <= isRead_d;
      nack_q     <= nack_d;
      sdaOe_q    <= sdaOe_d;
      sdaO_q     <= 1'b0;  // open drain: only ever pulls low
      wrStrobe_q <= wrStrobe_d;
      rdStrobe_q <= rdStrobe_d;
    end
  end

  // every output is a flop; the 3-cycle sync delay is far inside a fast-mode low phase
  assign link.slaveSdaO  = sdaO_q;
  assign link.slaveSdaOe = sdaOe_q;
  assign regPtr          = ptr_q;
  assign accAddr         = accAddr_q;
  assign wrData          = wrData_q;
  assign wrStrobe        = wrStrobe_q;
  assign rdStrobe        = rdStrobe_q;
endmodule : rtc_i2c_slave_port
`default_nettype wire

// [src/rtc_i2c_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_bus_master #(
  parameter int QuarterCycles = rtc_i2c_pkg::SCL_QUARTER_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  rtc_i2c_if.master       link,
  input  wire logic       cmdValid,
  input  wire logic [1:0] cmdOp,
  input  wire logic [7:0] cmdData,
  input  wire logic       cmdAck,
  output logic            cmdReady,
  output logic            rspValid,
  output logic      [7:0] rspData,
  output logic            rspAck
);
  logic sdaS;

  rtc_i2c_pkg::master_state_t state_q;
  rtc_i2c_pkg::master_state_t state_d;
  logic [7:0] qCnt_q;
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [3:0] bitIdx_q;
  logic [3:0] bitIdx_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic       read_q;
  logic       read_d;
  logic       ackOut_q;
  logic       ackOut_d;
  logic       sclOe_q;
  logic       sclOe_d;
  logic       sdaOe_q;
  logic       sdaOe_d;
  logic       ready_q;
  logic       ready_d;
  logic       rspValid_q;
  logic       rspValid_d;
  logic       rspAck_q;
  logic       rspAck_d;
  logic       lineO_q;

  i2c_line_sync u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .sclIn    (link.scl),
    .sdaIn    (link.sda),
    .sclS     (),
    .sdaS     (sdaS),
    .sclRise  (),
    .sclFall  (),
    .startDet (),
    .stopDet  ()
  );

  // quarter-bit tick; four quarters make one serial clock pulse
  logic qTick;
  logic ackSlot;
  assign qTick   = (qCnt_q == 8'(QuarterCycles - 1));
  assign ackSlot = (bitIdx_q == rtc_i2c_pkg::ACK_BIT_IDX);

  // phase 0 sets data with clock low, 1 raises clock, 2 samples, 3 lowers clock
  always_comb begin
    state_d    = state_q;
    phase_d    = phase_q;
    bitIdx_d   = bitIdx_q;
    shift_d    = shift_q;
    read_d     = read_q;
    ackOut_d   = ackOut_q;
    sclOe_d    = sclOe_q;
    sdaOe_d    = sdaOe_q;
    ready_d    = ready_q;
    rspAck_d   = rspAck_q;
    rspValid_d = 1'b0;
    if (state_q == rtc_i2c_pkg::M_IDLE) begin
      if (cmdValid) begin
        ready_d  = 1'b0;
        phase_d  = 2'h0;
        bitIdx_d = 4'h0;
        shift_d  = cmdData;
        ackOut_d = cmdAck;
        read_d   = (cmdOp == rtc_i2c_pkg::OP_READ);
        unique case (rtc_i2c_pkg::master_op_t'(cmdOp))
          rtc_i2c_pkg::OP_START: state_d = rtc_i2c_pkg::M_START;
          rtc_i2c_pkg::OP_STOP:  state_d = rtc_i2c_pkg::M_STOP;
          rtc_i2c_pkg::OP_WRITE: state_d = rtc_i2c_pkg::M_BIT;
          rtc_i2c_pkg::OP_READ:  state_d = rtc_i2c_pkg::M_BIT;
        endcase
      end
    end else if (qTick) begin
      phase_d = phase_q + 2'h1;
      unique case (state_q)
        rtc_i2c_pkg::M_START: begin
          // release data first so a repeated start works from mid-transfer
          unique case (phase_q)
            2'h0: sdaOe_d = 1'b0;
            2'h1: sclOe_d = 1'b0;
            2'h2: sdaOe_d = 1'b1;
            2'h3: sclOe_d = 1'b1;
          endcase
        end
        rtc_i2c_pkg::M_STOP: begin
          unique case (phase_q)
            2'h0: sdaOe_d = 1'b1;
            2'h1: sclOe_d = 1'b0;
            2'h2: sdaOe_d = 1'b0;
            2'h3: sclOe_d = 1'b0;
          endcase
        end
        default: begin
          unique case (phase_q)
            2'h0: sdaOe_d = ackSlot ? (read_q & ackOut_q) : (~read_q & ~shift_q[7]);
            2'h1: sclOe_d = 1'b0;
            2'h2: begin
              if (ackSlot) begin
                rspAck_d = ~sdaS;
              end else begin
                shift_d = {shift_q[6:0], sdaS};
              end
            end
            2'h3: begin
              sclOe_d  = 1'b1;
              bitIdx_d = bitIdx_q + 4'h1;
            end
          endcase
        end
      endcase
      if (phase_q == 2'h3 && (state_q != rtc_i2c_pkg::M_BIT || ackSlot)) begin
        state_d    = rtc_i2c_pkg::M_IDLE;
        ready_d    = 1'b1;
        rspValid_d = (state_q == rtc_i2c_pkg::M_BIT);  // data holds; next command moves it with clock low
      end
    end
  end

  // quarter timer restarts with every command
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      qCnt_q <= 8'h00;
    end else if (state_q == rtc_i2c_pkg::M_IDLE || qTick) begin
      qCnt_q <= 8'h00;
    end else begin
      qCnt_q <= qCnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q    <= rtc_i2c_pkg::M_IDLE;
      phase_q    <= 2'h0;
      bitIdx_q   <= 4'h0;
      shift_q    <= 8'h00;
      read_q     <= 1'b0;
      ackOut_q   <= 1'b0;
      sclOe_q    <= 1'b0;
      sdaOe_q    <= 1'b0;
      ready_q    <= 1'b1;
      rspValid_q <= 1'b0;
      rspAck_q   <= 1'b0;
      lineO_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      bitIdx_q   <= bitIdx_d;
      shift_q    <= shift_d;
      read_q     <= read_d;
      ackOut_q   <= ackOut_d;
      sclOe_q    <= sclOe_d;
      sdaOe_q    <= sdaOe_d;
      ready_q    <= ready_d;
      rspValid_q <= rspValid_d;
      rspAck_q   <= rspAck_d;
      lineO_q    <= 1'b0;
    end
  end

  assign link.masterSclO  = lineO_q;
  assign link.masterSclOe = sclOe_q;
  assign link.masterSdaO  = lineO_q;
  assign link.masterSdaOe = sdaOe_q;
  assign cmdReady         = ready_q;
  assign rspValid         = rspValid_q;
  assign rspData          = shift_q;
  assign rspAck           = rspAck_q;
endmodule : rtc_i2c_bus_master
`default_nettype wire

// [testbench/rtc_i2c_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic masterSclO,
  input wire logic masterSclOe,
  input wire logic masterSdaO,
  input wire logic masterSdaOe,
  input wire logic slaveSdaO,
  input wire logic slaveSdaOe,
  input wire logic scl,
  input wire logic sda
);
  logic       sclPrev_q;
  logic       sdaPrev_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic       firstByte_q;
  logic       selected_q;
  logic       readDir_q;
  logic       ignore_q;
  logic       nack_q;
  logic       idle_q;

  // bus events decoded from the resolved lines, one cycle of history
  wire startEv = scl & sclPrev_q & sdaPrev_q & ~sda;
  wire stopEv  = scl & sclPrev_q & ~sdaPrev_q & sda;
  wire riseEv  = scl & ~sclPrev_q;
  wire ackRise = riseEv & (bitCnt_q == 4'h8);
  wire dirRise = riseEv & (bitCnt_q == 4'h7) & firstByte_q;
  wire addrHit = (shift_q[6:0] == rtc_i2c_pkg::SLAVE_ADDR);

  // transfer tracker; a start overrides every other event in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {sclPrev_q, sdaPrev_q, idle_q} <= 3'h7;
      {firstByte_q, selected_q, readDir_q, ignore_q, nack_q} <= 5'h00;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
    end else begin
      sclPrev_q <= scl;
      sdaPrev_q <= sda;
      shift_q   <= riseEv ? {shift_q[6:0], sda} : shift_q;
      if (startEv) begin
        bitCnt_q <= 4'h0;
        {firstByte_q, selected_q, readDir_q, ignore_q, nack_q, idle_q} <= 6'h20;
      end else begin
        if (riseEv) bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
        if (ackRise) firstByte_q <= 1'b0;
        if (dirRise) {selected_q, readDir_q, ignore_q} <= {addrHit, sda, ~addrHit};
        if (ackRise & readDir_q & ~firstByte_q & sda) nack_q <= 1'b1;
        if (stopEv) idle_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_start_released : assert property (startEv |-> !slaveSdaOe)
    else $error("slave pulls data at a start");
  a_stop_idle : assert property (idle_q |-> !slaveSdaOe)
    else $error("slave pulls data on an idle bus");
  a_change_clock_low : assert property ($changed(slaveSdaOe) |-> !scl)
    else $error("slave data changed while clock high");
  a_hold_while_high : assert property ((scl && sclPrev_q) |-> $stable(slaveSdaOe))
    else $error("slave data moved during clock high");
  a_write_no_drive : assert property ((riseEv && bitCnt_q != 4'h8 && !readDir_q) |-> !slaveSdaOe)
    else $error("slave drove a bit of a master byte");
  a_data_ack_low : assert property ((ackRise && !firstByte_q && !readDir_q && selected_q) |-> (!sda)[*4])
    else $error("write data byte not acknowledged");
  a_reader_releases : assert property ((ackRise && readDir_q && !firstByte_q) |-> !slaveSdaOe)
    else $error("slave pulls data in the master ack bit");
  a_nack_releases : assert property (nack_q |-> !slaveSdaOe)
    else $error("slave kept sending after a nack");
  a_mismatch_quiet : assert property (ignore_q |-> !slaveSdaOe)
    else $error("slave active after a foreign address");
  a_addr_nack : assert property ((ackRise && firstByte_q && !selected_q) |-> sda)
    else $error("slave acknowledged a foreign address");
  a_master_data_hold : assert property (($changed(masterSdaOe) && !(startEv || stopEv)) |-> (!scl && !sclPrev_q))
    else $error("master data changed outside clock low");

  c_write_ack : cover property (ackRise && !firstByte_q && !readDir_q && selected_q);
  c_read_nack : cover property ($rose(nack_q));
  c_restart   : cover property (startEv && !idle_q);
endmodule : rtc_i2c_monitor
`default_nettype wire

// [testbench/rtc_i2c_slave_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_slave_port_test;
  localparam int         Quarter = 4;  // twice the shortest quarter the slave's input sync tolerates
  localparam logic [7:0] AddrWr  = {rtc_i2c_pkg::SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AddrRd  = {rtc_i2c_pkg::SLAVE_ADDR, 1'b1};
  logic        sys_clk;
  logic        rst;
  logic        cmdValid;
  logic [1:0]  cmdOp;
  logic [7:0]  cmdData;
  logic        cmdAck;
  logic        cmdReady;
  logic        rspValid;
  logic [7:0]  rspData;
  logic        rspAck;
  logic        powerFail;
  logic [7:0]  rdData;
  logic [7:0]  regPtr;
  logic [7:0]  accAddr;
  logic [7:0]  wrData;
  logic        wrStrobe;
  logic        rdStrobe;
  logic        sclPrev;
  logic [8:0]  wireBits;
  logic [15:0] wrLog[$];
  logic [7:0]  rdLog[$];
  int          err_count;
  int          n_tests;

  rtc_i2c_if busIf ();
  rtc_i2c_bus_master #(.QuarterCycles(Quarter)) rtc_i2c_bus_master_i (.sys_clk(sys_clk), .rst(rst),
    .link(busIf), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdData(cmdData), .cmdAck(cmdAck),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .rspAck(rspAck));
  rtc_i2c_slave_port rtc_i2c_slave_port_i (.sys_clk(sys_clk), .rst(rst), .link(busIf),
    .powerFail(powerFail), .rdData(rdData), .regPtr(regPtr), .accAddr(accAddr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe));
  rtc_i2c_monitor rtc_i2c_monitor_i (.sys_clk(sys_clk), .rst(rst), .masterSclO(busIf.masterSclO),
    .masterSclOe(busIf.masterSclOe), .masterSdaO(busIf.masterSdaO), .masterSdaOe(busIf.masterSdaOe),
    .slaveSdaO(busIf.slaveSdaO), .slaveSdaOe(busIf.slaveSdaOe), .scl(busIf.scl), .sda(busIf.sda));

  // register file stand-in: content is a fixed function of the pointer
  assign rdData = regPtr ^ 8'ha5;

  always #20 sys_clk = ~sys_clk;

  // wire-level view: bits as sampled at each clock rise, and every strobe the slave raises
  always @(posedge sys_clk) begin
    sclPrev <= busIf.scl;
    if (busIf.scl && !sclPrev) begin
      wireBits <= {wireBits[7:0], busIf.sda};
    end
    if (wrStrobe === 1'b1) begin
      wrLog.push_back({accAddr, wrData});
    end
    if (rdStrobe === 1'b1) begin
      rdLog.push_back(accAddr);
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic report_and_stop;
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // a byte takes 145 cycles here, so 400 means the master hung
  task automatic wait_ready;
    int n;
    n = 0;
    while (cmdReady !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 400) begin
        err_count++;
        report_and_stop();
      end
    end
  endtask : wait_ready

  task automatic bus_op(input logic [1:0] op, input logic [7:0] d, input logic ack);
    wait_ready();
    cmdOp    = op;
    cmdData  = d;
    cmdAck   = ack;
    cmdValid = 1'b1;
    @(posedge sys_clk);
    #1;
    cmdValid = 1'b0;
    wait_ready();
  endtask : bus_op

  task automatic stop_bus;
    bus_op(rtc_i2c_pkg::OP_STOP, 8'h00, 1'b0);
    chk1("idle sda", 1'b1, busIf.sda);
    chk1("idle scl", 1'b1, busIf.scl);
  endtask : stop_bus

  task automatic wr(input logic [7:0] b, input logic ack);
    bus_op(rtc_i2c_pkg::OP_WRITE, b, 1'b0);
    chk1("rsp valid", 1'b1, rspValid);
    chk1("slave ack", ack, rspAck);
    chk8("wire byte", b, wireBits[8:1]);
    chk1("wire ack", ~ack, wireBits[0]);
  endtask : wr

  task automatic rd(input logic ack, input logic [7:0] exp);
    bus_op(rtc_i2c_pkg::OP_READ, 8'h00, ack);
    chk1("rsp valid", 1'b1, rspValid);
    chk8("read byte", exp, rspData);
    chk8("wire byte", exp, wireBits[8:1]);
  endtask : rd

  task automatic scen_write;
    logic [7:0] bytes [3];
    bytes = '{8'h3c, 8'h5a, 8'hc3};
    wrLog.delete();
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr(AddrWr, 1'b1);
    wr(8'h10, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(bytes[i], 1'b1);
    end
    stop_bus();
    chk8("pointer", 8'h13, regPtr);
    chk8("writes", 8'h03, 8'(wrLog.size()));
    for (int i = 0; i < 3; i++) begin
      chk8("write addr", 8'h10 + 8'(i), wrLog[i][15:8]);
      chk8("write data", bytes[i], wrLog[i][7:0]);
    end
  endtask : scen_write

  // no pointer byte: read resumes where the write left the pointer
  task automatic scen_read;
    rdLog.delete();
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr(AddrRd, 1'b1);
    rd(1'b1, 8'h13 ^ 8'ha5);
    rd(1'b0, 8'h14 ^ 8'ha5);
    stop_bus();
    chk8("pointer", 8'h15, regPtr);
    chk8("read addr", 8'h13, rdLog[0]);
    chk8("read addr", 8'h14, rdLog[1]);
  endtask : scen_read

  // repeated start turns a pointer write into a read that wraps past the top
  task automatic scen_restart;
    wrLog.delete();
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr(AddrWr, 1'b1);
    wr(8'hfe, 1'b1);
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr(AddrRd, 1'b1);
    rd(1'b1, 8'hfe ^ 8'ha5);
    rd(1'b0, 8'hff ^ 8'ha5);
    stop_bus();
    chk8("pointer", 8'h00, regPtr);
    chk8("writes", 8'h00, 8'(wrLog.size()));
  endtask : scen_restart

  // foreign addresses one bit off at either end, then a blocked supply
  task automatic scen_refused;
    wrLog.delete();
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr({7'h69, 1'b0}, 1'b0);
    wr(8'h77, 1'b0);
    stop_bus();
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr({7'h28, 1'b1}, 1'b0);
    stop_bus();
    powerFail = 1'b1;
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr(AddrWr, 1'b0);
    stop_bus();
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr(AddrRd, 1'b0);
    stop_bus();
    powerFail = 1'b0;
    chk8("pointer", 8'h00, regPtr);
    chk8("writes", 8'h00, 8'(wrLog.size()));
    bus_op(rtc_i2c_pkg::OP_START, 8'h00, 1'b0);
    wr(AddrWr, 1'b1);
    wr(8'h05, 1'b1);
    stop_bus();
    chk8("pointer", 8'h05, regPtr);
  endtask : scen_refused

  initial begin
    sys_clk   = 1'b0;
    rst       = 1'b1;
    cmdValid  = 1'b0;
    cmdOp     = 2'h0;
    cmdData   = 8'h00;
    cmdAck    = 1'b0;
    powerFail = 1'b0;
    err_count = 0;
    n_tests   = 0;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    @(posedge sys_clk);
    #1;
    scen_write();
    scen_read();
    scen_restart();
    scen_refused();
    report_and_stop();
  end
endmodule : rtc_i2c_slave_port_test
`default_nettype wire
